// File: rtl/flash_ctl_pkg.sv
package flash_ctl_pkg;

  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned BOOT_BAUD       = 38_400;
  localparam int unsigned BOOT_BIT_CYCLES = CLK_HZ / BOOT_BAUD;

  // Accepted start-bit low span
  localparam logic [15:0] BOOT_LOW_MIN = 16'(BOOT_BIT_CYCLES / 2);
  localparam logic [15:0] BOOT_LOW_MAX = 16'(BOOT_BIT_CYCLES * 2);
  localparam int unsigned BOOT_DATA_BITS = 8;

  localparam logic [2:0] SEL_READ_DATA = 3'h0;
  localparam logic [2:0] SEL_ADDR      = 3'h1;
  localparam logic [2:0] SEL_DATA      = 3'h2;
  localparam logic [2:0] SEL_CTRL      = 3'h3;
  localparam logic [2:0] SEL_BLOCK     = 3'h4;
  localparam logic [2:0] SEL_PUMP      = 3'h5;

  localparam int unsigned CTRL_PROGRAM_PUMP_ENABLE_BIT  = 0;
  localparam int unsigned CTRL_ERASE_PUMP_ENABLE_BIT   = 1;
  localparam int unsigned CTRL_PGM_BIT      = 2;
  localparam int unsigned CTRL_ERASE_BIT    = 3;
  localparam int unsigned CTRL_PROGRAM_VERIFY_ENABLE_BIT  = 4;
  localparam int unsigned CTRL_ERASE_VERIFY_ENABLE_BIT   = 5;
  localparam int unsigned CTRL_POST_BIT     = 6;

  localparam int unsigned PUMP_DEEP_BIT     = 8;
  localparam int unsigned PUMP_DISCH_BIT    = 7;
  localparam int unsigned PUMP_LOW_VDD_BIT  = 6;
  localparam int unsigned PUMP_NEG_SEL_LSB  = 4;
  localparam int unsigned PUMP_POS_SEL_LSB  = 0;

  localparam logic [16:0] ADDR_RST  = 17'h0_0000;
  localparam logic [15:0] DATA_RST  = 16'hFFFF;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  BLOCK_RST = 8'h00;
  localparam logic [3:0]  PUMP_RST  = 4'h0;
  localparam logic [15:0] READ_BUSY_VALUE = 16'hFFFF;
  localparam int unsigned MAX_ERASE_BLOCKS = 4;

  localparam logic [2:0] MODE_PROM        = 3'h1;
  localparam logic [2:0] MODE_USER_EXT    = 3'h4;
  localparam logic [2:0] MODE_USER_SINGLE = 3'h5;
  localparam logic [2:0] MODE_BOOT_EXT    = 3'h6;
  localparam logic [2:0] MODE_BOOT_SINGLE = 3'h7;
  localparam logic [1:0] MODE_CAPTURE_DELAY = 2'h2;

  localparam logic [31:0] BOOT_ROM_BASE  = 32'h0000_0000;
  localparam logic [31:0] BOOT_RAM_FIRST = 32'h0803_0000;
  localparam logic [31:0] BOOT_RAM_LAST  = 32'h0803_FFFF;

  localparam int unsigned PIN_SYNC_W = 45;
  localparam logic [44:0] PIN_SYNC_RST = 45'h60_0000_0001;

  typedef logic signed [7:0] decivolt_t;
  localparam decivolt_t NEG_00 = -8'sd90;
  localparam decivolt_t NEG_01 = -8'sd100;
  localparam decivolt_t NEG_10 = -8'sd80;
  localparam decivolt_t NEG_11 = -8'sd100;
  localparam decivolt_t POS_PE_00 = 8'sd90;
  localparam decivolt_t POS_PE_01 = 8'sd80;
  localparam decivolt_t POS_PE_10 = 8'sd100;
  localparam decivolt_t POS_PE_11 = 8'sd70;
  localparam decivolt_t POS_VF_00 = 8'sd40;
  localparam decivolt_t POS_VF_01 = 8'sd50;
  localparam decivolt_t POS_VF_10 = 8'sd60;
  localparam decivolt_t POS_VF_11 = 8'sd70;
  localparam decivolt_t LEVEL_OFF = 8'sd0;

  typedef enum logic [5:0] {
    OP_IDLE           = 6'b000001,
    OP_PROGRAM        = 6'b000010,
    OP_POST_PROGRAM   = 6'b000100,
    OP_ERASE          = 6'b001000,
    OP_PROGRAM_VERIFY = 6'b010000,
    OP_ERASE_VERIFY   = 6'b100000
  } op_mode_t;

  typedef enum logic [5:0] {
    RX_IDLE       = 6'b000001,
    RX_MEASURE    = 6'b000010,
    RX_WAIT_START = 6'b000100,
    RX_START      = 6'b001000,
    RX_DATA       = 6'b010000,
    RX_STOP       = 6'b100000
  } rx_state_t;

endpackage

// File: rtl/boot_link_if.sv
interface boot_link_if;
  logic        enable;
  logic        rx;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        frame_error;
  logic        locked;
  logic [15:0] bit_cycles;

  modport receiver (input enable, input rx, output byte_valid, output byte_data,
                    output frame_error, output locked, output bit_cycles);
  modport controller (output enable, output rx, input byte_valid, input byte_data,
                      input frame_error, input locked, input bit_cycles);
endinterface

// File: rtl/boot_serial_rx.sv
module boot_serial_rx (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  boot_link_if.receiver     link
);
  import flash_ctl_pkg::*;

  rx_state_t   state_r;
  logic        rx_prev_r;
  logic [15:0] cnt_r;
  logic [2:0]  bit_idx_r;
  logic [7:0]  shift_r;
  logic        falling;

  assign falling = rx_prev_r & ~link.rx;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= link.rx;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r          <= RX_IDLE;
      cnt_r            <= 16'h0000;
      bit_idx_r        <= 3'h0;
      shift_r          <= 8'h00;
      link.locked      <= 1'b0;
      link.bit_cycles  <= 16'h0000;
      link.byte_valid  <= 1'b0;
      link.byte_data   <= 8'h00;
      link.frame_error <= 1'b0;
    end else begin
      link.byte_valid  <= 1'b0;
      link.frame_error <= 1'b0;
      if (!link.enable) begin
        state_r     <= RX_IDLE;
        link.locked <= 1'b0;
      end else begin
        unique case (state_r)
          RX_IDLE: begin
            if (falling) begin
              state_r <= RX_MEASURE;
              cnt_r   <= 16'h0001;
            end
          end
          RX_MEASURE: begin
            if (!link.rx) begin
              if (cnt_r != 16'hFFFF) begin
                cnt_r <= cnt_r + 16'h0001;
              end
            end else if (cnt_r >= BOOT_LOW_MIN && cnt_r <= BOOT_LOW_MAX) begin
              link.bit_cycles <= cnt_r;
              link.locked     <= 1'b1;
              state_r         <= RX_WAIT_START;
            end else begin
              state_r <= RX_IDLE;
            end
          end
          RX_WAIT_START: begin
            if (falling) begin
              state_r <= RX_START;
              cnt_r   <= 16'h0000;
            end
          end
          RX_START: begin
            if (cnt_r >= {1'b0, link.bit_cycles[15:1]}) begin
              cnt_r     <= 16'h0000;
              bit_idx_r <= 3'h0;
              state_r   <= link.rx ? RX_WAIT_START : RX_DATA;
            end else begin
              cnt_r <= cnt_r + 16'h0001;
            end
          end
          RX_DATA: begin
            if (cnt_r >= link.bit_cycles - 16'h0001) begin
              cnt_r     <= 16'h0000;
              shift_r   <= {link.rx, shift_r[7:1]};
              bit_idx_r <= bit_idx_r + 3'h1;
              if (bit_idx_r == 3'(BOOT_DATA_BITS - 1)) begin
                state_r <= RX_STOP;
              end
            end else begin
              cnt_r <= cnt_r + 16'h0001;
            end
          end
          RX_STOP: begin
            if (cnt_r >= link.bit_cycles - 16'h0001) begin
              cnt_r   <= 16'h0000;
              state_r <= RX_WAIT_START;
              if (link.rx) begin
                link.byte_valid <= 1'b1;
                link.byte_data  <= shift_r;
              end else begin
                link.frame_error <= 1'b1;
              end
            end else begin
              cnt_r <= cnt_r + 16'h0001;
            end
          end
        endcase
      end
    end
  end

endmodule // boot_serial_rx

// File: rtl/flash_prog_ctrl.sv
// Contract
// - Status bit 8 set while erase pump on and negative pump below -7V.
// - Status bit 7 set once negative pump discharged above -1V.
// - Status bit 6 set when any pump on and supply below 2.9V.
// - Bits 5:4 pick negative gate level: -9, -10, -8, -10 V.
// - Status bits 3:2 reserved, read zero, writes ignored.
// - Bits 1:0 pick positive gate level for program/erase: 9, 8, 10, 7 V.
// - In verify the positive field picks 4, 5, 6, 7 V.
// - Mode pins 6 or 7 at reset: boot mode, boot ROM at zero.
// - Boot mode stores UART0 download into RAM 0x08030000..0x0803FFFF.
// - Boot entry measures incoming low period to set bit timing.
// - Mode pins 4 or 5 select user program mode.
// - Array is unreadable while program or erase runs.
// - One program operation writes one 16-bit word.
// - Erase all selected blocks at once; at most four selected.
// - PROM write strobe rising edge latches data into selected register; select 001 loads address and data, selects 000 and 010 ignore writes.
// - PROM output enable low drives selected register onto data bus.
// - Five operation modes entered via control register; pre-program equals program.
// - Select 011 writes low byte to control register, reads it back.
module flash_prog_ctrl (
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire logic [2:0]              mode_pins,
  input  wire logic [2:0]              prom_register_select,
  input  wire logic                    prom_write_strobe_n,
  input  wire logic                    prom_output_enable_n,
  input  wire logic [16:0]             prom_address_bus,
  input  wire logic [15:0]             prom_data_bus_in,
  output logic      [15:0]             prom_data_bus_out,
  output logic                         prom_data_bus_oe,
  input  wire logic                    neg_pump_below_deep,
  input  wire logic                    neg_pump_above_discharge,
  input  wire logic                    supply_below_min,
  input  wire logic [15:0]             array_read_data,
  input  wire logic                    boot_rx,
  output logic                         program_pump_enable,
  output logic                         erase_pump_enable,
  output logic                         program_pulse,
  output logic                         erase_pulse,
  output logic                         verify_read,
  output logic                         array_read_enable,
  output logic      [16:0]             array_address,
  output logic      [15:0]             array_write_data,
  output logic      [7:0]              erase_blocks,
  output flash_ctl_pkg::op_mode_t      op_mode,
  output flash_ctl_pkg::decivolt_t     neg_gate_target,
  output flash_ctl_pkg::decivolt_t     pos_gate_target,
  output logic      [8:0]              pump_status_voltage,
  output logic                         prom_mode,
  output logic                         boot_mode,
  output logic                         user_program_mode,
  output logic                         boot_rom_mapped,
  output logic                         boot_baud_locked,
  output logic                         boot_ram_we,
  output logic      [31:0]             boot_ram_addr,
  output logic      [7:0]              boot_ram_data,
  output logic                         boot_ram_full
);
  import flash_ctl_pkg::*;

  function automatic op_mode_t decode_op(input logic [7:0] c);
    if (c[CTRL_ERASE_VERIFY_ENABLE_BIT]) begin
      return OP_ERASE_VERIFY;
    end else if (c[CTRL_PROGRAM_VERIFY_ENABLE_BIT]) begin
      return OP_PROGRAM_VERIFY;
    end else if (c[CTRL_ERASE_BIT]) begin
      return OP_ERASE;
    end else if (c[CTRL_PGM_BIT] && c[CTRL_POST_BIT]) begin
      return OP_POST_PROGRAM;
    end else if (c[CTRL_PGM_BIT]) begin
      return OP_PROGRAM;
    end
    return OP_IDLE;
  endfunction

  function automatic logic blocks_ok(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, b[i]};
    end
    return (n != 4'h0) && (n <= 4'(MAX_ERASE_BLOCKS));
  endfunction

  function automatic decivolt_t neg_level(input logic [1:0] s);
    unique case (s)
      2'h0: return NEG_00;
      2'h1: return NEG_01;
      2'h2: return NEG_10;
      2'h3: return NEG_11;
    endcase
  endfunction

  function automatic decivolt_t pos_level(input logic [1:0] s, input logic vfy);
    unique case (s)
      2'h0: return vfy ? POS_VF_00 : POS_PE_00;
      2'h1: return vfy ? POS_VF_01 : POS_PE_01;
      2'h2: return vfy ? POS_VF_10 : POS_PE_10;
      2'h3: return vfy ? POS_VF_11 : POS_PE_11;
    endcase
  endfunction

  // Two-stage pin synchronisers
  logic [PIN_SYNC_W-1:0] pin_s1_r;
  logic [PIN_SYNC_W-1:0] pin_s2_r;
  logic                  we_n_d3_r;
  logic [2:0]            mode_s;
  logic [2:0]            sel_s;
  logic                  we_n_s;
  logic                  oe_n_s;
  logic [16:0]           addr_s;
  logic [15:0]           data_s;
  logic                  deep_s;
  logic                  disch_s;
  logic                  low_vdd_s;
  logic                  rx_s;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r  <= PIN_SYNC_RST;
      pin_s2_r  <= PIN_SYNC_RST;
      we_n_d3_r <= 1'b1;
    end else begin
      pin_s1_r  <= {mode_pins, prom_register_select, prom_write_strobe_n,
                    prom_output_enable_n, prom_address_bus, prom_data_bus_in,
                    neg_pump_below_deep, neg_pump_above_discharge,
                    supply_below_min, boot_rx};
      pin_s2_r  <= pin_s1_r;
      we_n_d3_r <= we_n_s;
    end
  end

  assign {mode_s, sel_s, we_n_s, oe_n_s, addr_s, data_s,
          deep_s, disch_s, low_vdd_s, rx_s} = pin_s2_r;

  // Strap captured once
  logic [1:0] cap_cnt_r;
  logic       cap_done_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_cnt_r         <= 2'h0;
      cap_done_r        <= 1'b0;
      prom_mode         <= 1'b0;
      boot_mode         <= 1'b0;
      user_program_mode <= 1'b0;
      boot_rom_mapped   <= 1'b0;
    end else if (!cap_done_r) begin
      if (cap_cnt_r == MODE_CAPTURE_DELAY) begin
        cap_done_r        <= 1'b1;
        prom_mode         <= (mode_s == MODE_PROM);
        boot_mode         <= (mode_s == MODE_BOOT_EXT) || (mode_s == MODE_BOOT_SINGLE);
        boot_rom_mapped   <= (mode_s == MODE_BOOT_EXT) || (mode_s == MODE_BOOT_SINGLE);
        user_program_mode <= (mode_s == MODE_USER_EXT) || (mode_s == MODE_USER_SINGLE);
      end else begin
        cap_cnt_r <= cap_cnt_r + 2'h1;
      end
    end
  end

  // PROM register file
  logic        wr_stb;
  logic [16:0] addr_r;
  logic [15:0] data_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  block_r;
  logic [3:0]  pump_sel_r;
  logic [2:0]  pump_flags_r;
  logic [8:0]  pump_word;

  assign wr_stb = prom_mode & we_n_s & ~we_n_d3_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= ADDR_RST;
      data_r <= DATA_RST;
    end else if (wr_stb && sel_s == SEL_ADDR) begin
      addr_r <= addr_s;
      data_r <= data_s;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_stb && sel_s == SEL_CTRL) begin
      ctrl_r <= data_s[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      block_r <= BLOCK_RST;
    end else if (wr_stb && sel_s == SEL_BLOCK) begin
      block_r <= data_s[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pump_sel_r <= PUMP_RST;
    end else if (wr_stb && sel_s == SEL_PUMP) begin
      pump_sel_r <= {data_s[PUMP_NEG_SEL_LSB+1 -: 2], data_s[PUMP_POS_SEL_LSB+1 -: 2]};
    end
  end

  // Live pump flags, read-only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pump_flags_r <= 3'h0;
    end else begin
      pump_flags_r[2] <= ctrl_r[CTRL_ERASE_PUMP_ENABLE_BIT] & deep_s;
      pump_flags_r[1] <= disch_s;
      pump_flags_r[0] <= (ctrl_r[CTRL_PROGRAM_PUMP_ENABLE_BIT] | ctrl_r[CTRL_ERASE_PUMP_ENABLE_BIT]) & low_vdd_s;
    end
  end

  assign pump_word = {pump_flags_r, pump_sel_r[3:2], 2'h0, pump_sel_r[1:0]};

  // Operation decode
  op_mode_t op_nxt;
  logic     busy_nxt;
  logic     vfy_nxt;

  assign op_nxt   = decode_op(ctrl_r);
  assign busy_nxt = (op_nxt == OP_PROGRAM) || (op_nxt == OP_POST_PROGRAM) ||
                    (op_nxt == OP_ERASE);
  assign vfy_nxt  = (op_nxt == OP_PROGRAM_VERIFY) || (op_nxt == OP_ERASE_VERIFY);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_mode             <= OP_IDLE;
      program_pump_enable <= 1'b0;
      erase_pump_enable   <= 1'b0;
      program_pulse       <= 1'b0;
      erase_pulse         <= 1'b0;
      verify_read         <= 1'b0;
      erase_blocks        <= 8'h00;
    end else begin
      op_mode             <= op_nxt;
      program_pump_enable <= ctrl_r[CTRL_PROGRAM_PUMP_ENABLE_BIT];
      erase_pump_enable   <= ctrl_r[CTRL_ERASE_PUMP_ENABLE_BIT];
      program_pulse       <= ((op_nxt == OP_PROGRAM) || (op_nxt == OP_POST_PROGRAM)) &&
                             ctrl_r[CTRL_PROGRAM_PUMP_ENABLE_BIT];
      erase_pulse         <= (op_nxt == OP_ERASE) && ctrl_r[CTRL_ERASE_PUMP_ENABLE_BIT] &&
                             blocks_ok(block_r);
      verify_read         <= vfy_nxt;
      erase_blocks        <= (op_nxt == OP_ERASE) ? block_r : 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      array_read_enable <= 1'b0;
      array_address     <= ADDR_RST;
      array_write_data  <= DATA_RST;
    end else begin
      array_read_enable <= !busy_nxt &&
                           (vfy_nxt || (prom_mode && sel_s == SEL_READ_DATA && !oe_n_s));
      array_address     <= (sel_s == SEL_READ_DATA && !busy_nxt) ? addr_s : addr_r;
      array_write_data  <= data_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      neg_gate_target     <= LEVEL_OFF;
      pos_gate_target     <= LEVEL_OFF;
      pump_status_voltage <= 9'h000;
    end else begin
      neg_gate_target     <= ctrl_r[CTRL_ERASE_PUMP_ENABLE_BIT] ?
                             neg_level(pump_sel_r[3:2]) : LEVEL_OFF;
      if (vfy_nxt) begin
        pos_gate_target <= pos_level(pump_sel_r[1:0], 1'b1);
      end else if (ctrl_r[CTRL_PROGRAM_PUMP_ENABLE_BIT] || ctrl_r[CTRL_ERASE_PUMP_ENABLE_BIT]) begin
        pos_gate_target <= pos_level(pump_sel_r[1:0], 1'b0);
      end else begin
        pos_gate_target <= LEVEL_OFF;
      end
      pump_status_voltage <= pump_word;
    end
  end

  // PROM read-back
  logic [15:0] rd_val;

  always_comb begin
    rd_val = 16'h0000;
    unique case (sel_s)
      SEL_READ_DATA: rd_val = busy_nxt ? READ_BUSY_VALUE : array_read_data;
      SEL_ADDR:      rd_val = addr_r[16:1];
      SEL_DATA:      rd_val = data_r;
      SEL_CTRL:      rd_val = {8'h00, ctrl_r};
      SEL_BLOCK:     rd_val = {8'h00, block_r};
      SEL_PUMP:      rd_val = {7'h00, pump_word};
      default:       rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prom_data_bus_out <= 16'h0000;
      prom_data_bus_oe  <= 1'b0;
    end else begin
      prom_data_bus_out <= rd_val;
      prom_data_bus_oe  <= prom_mode & ~oe_n_s & we_n_s;
    end
  end

  // Serial boot download
  boot_link_if link ();

  assign link.enable = boot_mode;
  assign link.rx     = rx_s;

  boot_serial_rx u_boot_rx (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .link    (link.receiver)
  );

  logic [31:0] ram_ptr_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_ptr_r        <= BOOT_RAM_FIRST;
      boot_ram_we      <= 1'b0;
      boot_ram_addr    <= BOOT_RAM_FIRST;
      boot_ram_data    <= 8'h00;
      boot_ram_full    <= 1'b0;
      boot_baud_locked <= 1'b0;
    end else begin
      boot_baud_locked <= link.locked;
      boot_ram_we      <= 1'b0;
      if (link.byte_valid && !boot_ram_full) begin
        boot_ram_we   <= 1'b1;
        boot_ram_addr <= ram_ptr_r;
        boot_ram_data <= link.byte_data;
        ram_ptr_r     <= ram_ptr_r + 32'h0000_0001;
        boot_ram_full <= (ram_ptr_r == BOOT_RAM_LAST);
      end
    end
  end

endmodule // flash_prog_ctrl

// File: tb/flash_prog_ctrl_asserts.sv
module flash_prog_ctrl_chk
  import flash_ctl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        prom_mode,
  input wire logic        boot_mode,
  input wire logic        boot_rom_mapped,
  input wire logic        prom_output_enable_n,
  input wire logic        prom_data_bus_oe,
  input wire logic [8:0]  pump_status_voltage,
  input wire logic        erase_pump_enable,
  input wire logic        verify_read,
  input wire decivolt_t   neg_gate_target,
  input wire decivolt_t   pos_gate_target,
  input wire logic        erase_pulse,
  input wire logic        program_pulse,
  input wire logic [7:0]  erase_blocks,
  input wire op_mode_t    op_mode,
  input wire logic        boot_ram_we,
  input wire logic [31:0] boot_ram_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int neg_lv[4] = '{-90, -100, -80, -100};
  localparam int pe_lv[4] = '{90, 80, 100, 70};
  localparam int vf_lv[4] = '{40, 50, 60, 70};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence read_req;
    $fell(prom_output_enable_n) && prom_mode;
  endsequence
  sequence bus_driven;
    ##[1:4] prom_data_bus_oe;
  endsequence
  AST_READ_OE: assert property (read_req |-> bus_driven)
    else $error("no read drive");
  AST_NO_DRIVE: assert property (!prom_mode |-> !prom_data_bus_oe)
    else $error("stray drive");
  AST_RSVD: assert property (pump_status_voltage[3:2] == 2'b00)
    else $error("reserved set");
  AST_DEEP: assert property (pump_status_voltage[8] |-> $past(erase_pump_enable))
    else $error("stray deep flag");
  AST_NEG_OFF: assert property (!erase_pump_enable [*3] |-> neg_gate_target == 0)
    else $error("neg not off");
  AST_NEG_LVL: assert property ((erase_pump_enable && $stable(pump_status_voltage[5:4])) [*3]
    |-> neg_gate_target == neg_lv[pump_status_voltage[5:4]])
    else $error("neg level");
  AST_POS_PE: assert property ((erase_pump_enable && !verify_read &&
    $stable(pump_status_voltage[1:0])) [*3]
    |-> pos_gate_target == pe_lv[pump_status_voltage[1:0]])
    else $error("pos level");
  AST_POS_VF: assert property ((verify_read && $stable(pump_status_voltage[1:0])) [*3]
    |-> pos_gate_target == vf_lv[pump_status_voltage[1:0]])
    else $error("vfy level");
  AST_ERASE: assert property (erase_pulse |-> erase_blocks != 8'h00 &&
    $countones(erase_blocks) <= 4 && op_mode == OP_ERASE)
    else $error("bad erase");
  AST_PGM: assert property (program_pulse |-> op_mode inside {OP_PROGRAM, OP_POST_PROGRAM})
    else $error("bad program");
  AST_BOOT: assert property (boot_mode |-> boot_rom_mapped && !prom_mode)
    else $error("bad boot");
  AST_RAM: assert property (boot_ram_we |->
    boot_ram_addr inside {[32'h0803_0000:32'h0803_FFFF]})
    else $error("bad ram addr");
endmodule // flash_prog_ctrl_chk

// File: tb/prom_host.sv
module prom_host
  import flash_ctl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] dout,
  input  wire logic        doe,
  output logic      [2:0]  sel,
  output logic             wstb_n,
  output logic             oe_n,
  output logic      [16:0] addr,
  output logic      [15:0] data,
  output logic             rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sel = 3'h0;
    wstb_n = 1'b1;
    oe_n = 1'b1;
    addr = 17'h0_0000;
    data = 16'h0000;
    rx = 1'b1;
  end
  task automatic wr(input logic [2:0] s, input logic [15:0] d,
                    input logic [16:0] a = 17'h0_0000);
    @(posedge sys_clk);
    sel <= s;
    addr <= a;
    data <= d;
    repeat (3) @(posedge sys_clk);
    wstb_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    wstb_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    data <= ~d;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] s, output logic [15:0] q);
    @(posedge sys_clk);
    sel <= s;
    oe_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    q = doe ? dout : 16'hxxxx;
    oe_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic tx(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx <= f[i];
      repeat (BOOT_BIT_CYCLES) @(posedge sys_clk);
    end
  endtask
endmodule // prom_host

// File: tb/tb.sv
module tb;
  import flash_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, prom_write_strobe_n, prom_output_enable_n, boot_rx, prom_data_bus_oe;
  logic neg_pump_below_deep, neg_pump_above_discharge, supply_below_min, program_pump_enable;
  logic erase_pump_enable, program_pulse, erase_pulse, verify_read, array_read_enable;
  logic prom_mode, boot_mode, user_program_mode, boot_rom_mapped, boot_baud_locked;
  logic boot_ram_we, boot_ram_full;
  logic [2:0] mode_pins, prom_register_select;
  logic [16:0] prom_address_bus, array_address;
  logic [15:0] prom_data_bus_in, prom_data_bus_out, array_read_data, array_write_data, q;
  logic [7:0] erase_blocks, boot_ram_data, got_byte;
  logic [8:0] pump_status_voltage;
  logic [31:0] boot_ram_addr, got_addr;
  op_mode_t op_mode;
  decivolt_t neg_gate_target, pos_gate_target;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  flash_prog_ctrl i_flash_prog_ctrl (.*);
  prom_host host (.sys_clk, .dout(prom_data_bus_out), .doe(prom_data_bus_oe),
    .sel(prom_register_select), .wstb_n(prom_write_strobe_n), .oe_n(prom_output_enable_n),
    .addr(prom_address_bus), .data(prom_data_bus_in), .rx(boot_rx));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (boot_ram_we) begin
      got_addr <= boot_ram_addr;
      got_byte <= boot_ram_data;
    end
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic [2:0] m);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    mode_pins <= m;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic t_regs;
    host.rd(SEL_DATA, q);
    chk(q, 16'hFFFF);
    host.wr(SEL_ADDR, 16'hA5C3, 17'h1_2345);
    host.rd(SEL_ADDR, q);
    chk(q, 16'h91A2);
    host.rd(SEL_DATA, q);
    chk(q, 16'hA5C3);
    host.wr(SEL_PUMP, 16'h01FF);
    host.rd(SEL_PUMP, q);
    chk(q, 16'h0033);
    $display("t_regs done");
  endtask
  task automatic t_levels;
    int ng[4] = '{-90, -100, -80, -100};
    int pe[4] = '{90, 80, 100, 70};
    int vf[4] = '{40, 50, 60, 70};
    for (int k = 0; k < 2; k++) begin
      host.wr(SEL_CTRL, k ? 16'h0010 : 16'h0002);
      for (int i = 0; i < 4; i++) begin
        host.wr(SEL_PUMP, 16'(i * 17));
        chk(16'(neg_gate_target), 16'(k ? 0 : ng[i]));
        chk(16'(pos_gate_target), 16'(k ? vf[i] : pe[i]));
      end
    end
    host.rd(SEL_CTRL, q);
    chk(q, 16'h0010);
    $display("t_levels done");
  endtask
  task automatic t_flags;
    host.wr(SEL_CTRL, 16'h0002);
    neg_pump_below_deep <= 1'b1;
    supply_below_min <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(16'(pump_status_voltage[8:6]), 16'h5);
    host.wr(SEL_CTRL, 16'h0000);
    neg_pump_above_discharge <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(16'(pump_status_voltage[8:6]), 16'h2);
    $display("t_flags done");
  endtask
  task automatic t_ops;
    logic [15:0] c[5] = '{16'h0005, 16'h0010, 16'h000A, 16'h0020, 16'h0045};
    logic [5:0] m[5] = '{6'h02, 6'h10, 6'h08, 6'h20, 6'h04};
    logic [2:0] p[5] = '{3'h4, 3'h1, 3'h2, 3'h1, 3'h4};
    array_read_data <= 16'h1234;
    host.wr(SEL_BLOCK, 16'h000F);
    host.wr(SEL_ADDR, 16'h5A5A, 17'h0_0040);
    for (int i = 0; i < 5; i++) begin
      host.wr(SEL_CTRL, c[i]);
      chk(16'(op_mode), 16'(m[i]));
      chk(16'({program_pulse, erase_pulse, verify_read}), 16'(p[i]));
      host.rd(SEL_READ_DATA, q);
      chk(q, i[0] ? 16'h1234 : 16'hFFFF);
    end
    chk(array_write_data, 16'h5A5A);
    host.wr(SEL_CTRL, 16'h000A);
    host.wr(SEL_BLOCK, 16'h001F);
    chk(16'(erase_pulse), 16'h0);
    chk(16'({erase_pump_enable, erase_blocks}), 16'h011F);
    $display("t_ops done");
  endtask
  task automatic t_modes;
    rst(MODE_USER_EXT);
    chk(16'({user_program_mode, boot_mode, prom_mode}), 16'h4);
    rst(MODE_BOOT_SINGLE);
    chk(16'({boot_mode, boot_rom_mapped, user_program_mode}), 16'h6);
    host.tx(8'hFF);
    chk(16'(boot_baud_locked), 16'h1);
    host.tx(8'hC3);
    repeat (20) @(posedge sys_clk);
    chk(16'(got_byte), 16'hC3);
    chk(16'(got_addr == 32'h0803_0000), 16'h1);
    $display("t_modes done");
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    mode_pins = MODE_PROM;
    neg_pump_below_deep = 1'b0;
    neg_pump_above_discharge = 1'b0;
    supply_below_min = 1'b0;
    array_read_data = 16'h0000;
    rst(MODE_PROM);
    t_regs();
    t_levels();
    t_flags();
    t_ops();
    t_modes();
    end_sim();
  end
endmodule // tb
bind flash_prog_ctrl flash_prog_ctrl_chk i_chk (.*);
